// File: pkg/msq_defs.svh
/*
 Timing constants of the measurement trigger and end-of-conversion sequencer.
 Assumes a 100 MHz ref_clk; all phase lengths are counted in 10 us ticks.
*/
`ifndef MSQ_DEFS_SVH
`define MSQ_DEFS_SVH

// Timebase
`define MSQ_CLK_NS        10
`define MSQ_TICK_US       10
`define MSQ_MS_US         1000
`define MSQ_TICK_CYC      (`MSQ_TICK_US * 1000 / `MSQ_CLK_NS)
`define MSQ_TK(us)        ((us) / `MSQ_TICK_US)

// Measurement interval, single quantity, in us
`define MSQ_S_XQ_US       3400
`define MSQ_S_FAST_US     11400
`define MSQ_S_MED50_US    41400
`define MSQ_S_MED60_US    34400
`define MSQ_S_SLOW50_US   156400
`define MSQ_S_SLOW60_US   149800

// Measurement interval, resistance plus voltage, in us
`define MSQ_C_XQ_US       6800
`define MSQ_C_FAST_US     22800
`define MSQ_C_MED50_US    82800
`define MSQ_C_MED60_US    68800
`define MSQ_C_SLOW50_US   257800
`define MSQ_C_SLOW60_US   251200

// Fixed overhead when averaging under external trigger, in us
`define MSQ_C_OVH_US      2800
`define MSQ_S_OVH_US      1400
`define MSQ_C_OVH50_US    57800
`define MSQ_C_OVH60_US    51200
`define MSQ_S_OVH50_US    56400
`define MSQ_S_OVH60_US    49800

// Calculation interval and its additions, in us
`define MSQ_CALC_US       300
`define MSQ_STATS_US      300
`define MSQ_REFTOL_US     150

// End-of-conversion hold under internal trigger, in us
`define MSQ_HOLD_XQ_US    1000
`define MSQ_HOLD_FAST_US  5000
`define MSQ_HOLD_MED_US   20000
`define MSQ_HOLD_SLOW_US  50000

`endif

// File: pkg/msq_pkg.sv
/*
 Types of the measurement sequencer: sampling rate, cycle phase and the
 configuration bundle. Assumes the configuration comes from same-clock logic.
*/
package msq_pkg;

   typedef enum logic [1:0] {
      rate_extra_quick,
      rate_fast,
      rate_medium,
      rate_slow
   } msq_rate_t;

   typedef enum logic [1:0] {
      st_idle,
      st_delay,
      st_meas,
      st_calc
   } msq_state_t;

   typedef struct packed {
      logic        start_strobe_n_internal;
      logic        eoc_pulse;
      logic        err_sync;
      logic        combined;
      logic        line_60hz;
      logic        stats_on;
      logic        ref_tol;
      logic        avg_on;
      msq_rate_t   rate;
      logic [7:0]  avg_n;
      logic [15:0] delay_ticks;
      logic [15:0] pulse_ms;
   } msq_cfg_t;

endpackage : msq_pkg

// File: rtl/msq_tick_gen.sv
/*
 Timebase prescaler: one-cycle tick every CYCLES clocks.
 Assumes a single free-running ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module msq_tick_gen
#(
   parameter int CYCLES = 1000
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Tick
   output logic      tick
);

   logic [31:0] div_reg;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= 32'h0;
         tick    <= 1'b0;
      end
      else if (div_reg == 32'(CYCLES - 1))
      begin
         div_reg <= 32'h0;
         tick    <= 1'b1;
      end
      else
      begin
         div_reg <= div_reg + 32'h1;
         tick    <= 1'b0;
      end
   end

endmodule : msq_tick_gen

`default_nettype wire

// File: rtl/msq_sequencer.sv
/*
 Measurement cycle sequencer behind the external control port: start
 strobe, delay, measurement, calculation, end-of-conversion and fault.
 Assumes start_strobe_n and fault_in are asynchronous pins; cfg and
 comp_in come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msq_defs.svh"

// Functional notes
// (RULE1) End-of-conversion style: latched level or timed pulse
// (RULE2) Pulse width is set in milliseconds
// (RULE3) Controller holds start low at least 0.5 ms
// (RULE4) Fault output follows fault within 1.5 ms
// (RULE5) Measurement length from rate, line, mode
// (RULE6) Calculation 0.3 ms plus statistics, tolerance additions
// (RULE7) External latched: held until next start strobe
// (RULE8) Pulse style: asserted for programmed width only
// (RULE9) Internal latched: fixed hold time per rate
// (RULE10) Internal averaging keeps measurement length unchanged
// (RULE11) External averaging scales length, fast rates
// (RULE12) External averaging at slow rate, larger overhead
// (RULE13) Synchronous fault published with end-of-conversion
// (RULE14) Controller waits settling time before start
// (RULE15) External: one cycle per falling start edge
// (RULE16) Start strobe ignored under internal triggering
// (RULE17) Removal indicator low only while measuring
// (RULE18) Power-up: end-of-conversion and removal asserted
// (RULE19) Delay, measure, calculate, then results together
module msq_sequencer
#(
   parameter int TICK_CYCLES = `MSQ_TICK_CYC,
   parameter int COMP_W      = 7
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // External control pins
   input  wire logic              start_strobe_n,
   input  wire logic              fault_in,
   // Configuration and comparator judgment
   input  wire msq_pkg::msq_cfg_t cfg,
   input  wire logic [COMP_W-1:0] comp_in,
   // Status outputs
   output logic                   eoc,
   output logic                   removal_out,
   output logic                   fault_out,
   output logic [COMP_W-1:0]      comp_out
);

   function automatic logic [31:0] meas_base(input msq_pkg::msq_cfg_t c);
      logic [31:0] t;
      t = 32'h0;
      unique case (c.rate)
         msq_pkg::rate_extra_quick:
            t = c.combined ? `MSQ_TK(`MSQ_C_XQ_US) : `MSQ_TK(`MSQ_S_XQ_US);
         msq_pkg::rate_fast:
            t = c.combined ? `MSQ_TK(`MSQ_C_FAST_US) : `MSQ_TK(`MSQ_S_FAST_US);
         msq_pkg::rate_medium:
            if (c.combined)
               t = c.line_60hz ? `MSQ_TK(`MSQ_C_MED60_US) : `MSQ_TK(`MSQ_C_MED50_US);
            else
               t = c.line_60hz ? `MSQ_TK(`MSQ_S_MED60_US) : `MSQ_TK(`MSQ_S_MED50_US);
         msq_pkg::rate_slow:
            if (c.combined)
               t = c.line_60hz ? `MSQ_TK(`MSQ_C_SLOW60_US) : `MSQ_TK(`MSQ_C_SLOW50_US);
            else
               t = c.line_60hz ? `MSQ_TK(`MSQ_S_SLOW60_US) : `MSQ_TK(`MSQ_S_SLOW50_US);
      endcase
      return t; // see RULE5
   endfunction : meas_base

   function automatic logic [31:0] meas_len(input msq_pkg::msq_cfg_t c);
      logic [31:0] base;
      logic [31:0] ovh;
      base = meas_base(c);
      if (c.rate == msq_pkg::rate_slow)
      begin
         if (c.combined)
            ovh = c.line_60hz ? `MSQ_TK(`MSQ_C_OVH60_US) : `MSQ_TK(`MSQ_C_OVH50_US);
         else
            ovh = c.line_60hz ? `MSQ_TK(`MSQ_S_OVH60_US) : `MSQ_TK(`MSQ_S_OVH50_US);
      end
      else
         ovh = c.combined ? `MSQ_TK(`MSQ_C_OVH_US) : `MSQ_TK(`MSQ_S_OVH_US); // see RULE11
      // Internal trigger keeps a running average, so the length stays put
      if (c.avg_on && !c.start_strobe_n_internal && c.avg_n > 8'h01) // see RULE10
         return 32'((base - ovh) * {24'h0, c.avg_n} + ovh); // see RULE12
      return base;
   endfunction : meas_len

   function automatic logic [31:0] calc_len(input msq_pkg::msq_cfg_t c);
      logic [31:0] t;
      t = `MSQ_TK(`MSQ_CALC_US);
      if (c.stats_on)
         t = t + `MSQ_TK(`MSQ_STATS_US);
      if (c.ref_tol)
         t = t + `MSQ_TK(`MSQ_REFTOL_US);
      return t; // see RULE6
   endfunction : calc_len

   function automatic logic [31:0] hold_len(input msq_pkg::msq_rate_t r);
      logic [31:0] t;
      t = 32'h0;
      unique case (r)
         msq_pkg::rate_extra_quick: t = `MSQ_TK(`MSQ_HOLD_XQ_US);
         msq_pkg::rate_fast:        t = `MSQ_TK(`MSQ_HOLD_FAST_US);
         msq_pkg::rate_medium:      t = `MSQ_TK(`MSQ_HOLD_MED_US);
         msq_pkg::rate_slow:        t = `MSQ_TK(`MSQ_HOLD_SLOW_US);
      endcase
      return t; // see RULE9
   endfunction : hold_len

   logic                 tick;
   logic                 start_s1_reg;
   logic                 start_s2_reg;
   logic                 start_s3_reg;
   logic                 fault_s1_reg;
   logic                 fault_s2_reg;
   msq_pkg::msq_state_t  state_reg;
   logic [31:0]          cnt_reg;
   logic [31:0]          meas_len_reg;
   logic [31:0]          eoc_cnt_reg;
   logic                 eoc_timed_reg;
   logic                 fault_seen_reg;
   logic                 fall;
   logic                 start_ev;
   logic                 phase_end;
   logic                 done;

   msq_tick_gen
   #(
      .CYCLES (TICK_CYCLES)
   )
   u_tick
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick)
   );

   // Both pins are asynchronous; first stage feeds only the second
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         start_s1_reg <= 1'b1;
         start_s2_reg <= 1'b1;
         start_s3_reg <= 1'b1;
         fault_s1_reg <= 1'b0;
         fault_s2_reg <= 1'b0;
      end
      else
      begin
         start_s1_reg <= start_strobe_n;
         start_s2_reg <= start_s1_reg;
         start_s3_reg <= start_s2_reg;
         fault_s1_reg <= fault_in;
         fault_s2_reg <= fault_s1_reg;
      end
   end

   // A strobe shorter than one ref_clk period may be missed; the far side
   // keeps it low long enough (see RULE3) and lets the object settle (see RULE14)
   assign fall = start_s3_reg & ~start_s2_reg; // see RULE15
   // Edges outside idle are dropped: one cycle at a time
   assign start_ev = (state_reg == msq_pkg::st_idle) &&
                     (cfg.start_strobe_n_internal || fall); // see RULE16
   assign phase_end = (state_reg != msq_pkg::st_idle) && (cnt_reg == 32'h0);
   assign done = (state_reg == msq_pkg::st_calc) && (cnt_reg == 32'h0);

   // Cycle phases
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= msq_pkg::st_idle;
         cnt_reg      <= 32'h0;
         meas_len_reg <= 32'h0;
         removal_out  <= 1'b1; // see RULE18
      end
      else if (start_ev)
      begin
         state_reg    <= msq_pkg::st_delay;
         cnt_reg      <= {16'h0, cfg.delay_ticks};
         meas_len_reg <= meas_len(cfg);
      end
      else if (phase_end)
      begin
         unique case (state_reg)
            msq_pkg::st_delay:
            begin
               state_reg   <= msq_pkg::st_meas; // see RULE19
               cnt_reg     <= meas_len_reg;
               removal_out <= 1'b0; // see RULE17
            end
            msq_pkg::st_meas:
            begin
               state_reg   <= msq_pkg::st_calc;
               cnt_reg     <= calc_len(cfg);
               removal_out <= 1'b1;
            end
            default:
               state_reg   <= msq_pkg::st_idle;
         endcase
      end
      else if (tick && state_reg != msq_pkg::st_idle)
         cnt_reg <= cnt_reg - 32'h1;
   end

   // End-of-conversion; timed styles count ticks, latched waits for start
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         eoc           <= 1'b1; // see RULE18
         eoc_cnt_reg   <= 32'h0;
         eoc_timed_reg <= 1'b0;
      end
      else if (done)
      begin
         eoc           <= 1'b1;
         eoc_timed_reg <= cfg.eoc_pulse || cfg.start_strobe_n_internal; // see RULE1
         if (cfg.eoc_pulse)
            eoc_cnt_reg <= 32'(32'(cfg.pulse_ms) * (`MSQ_MS_US / `MSQ_TICK_US)); // see RULE2
         else
            eoc_cnt_reg <= hold_len(cfg.rate); // see RULE9
      end
      else if (!eoc_timed_reg)
      begin
         if (start_ev)
            eoc <= 1'b0; // see RULE7
      end
      else if (eoc_cnt_reg == 32'h0)
         eoc <= 1'b0; // see RULE8
      else if (tick)
         eoc_cnt_reg <= eoc_cnt_reg - 32'h1;
   end

   // Fault and comparator results
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         fault_seen_reg <= 1'b0;
         fault_out      <= 1'b0;
         comp_out       <= '0;
      end
      else
      begin
         if (phase_end && state_reg == msq_pkg::st_delay)
            fault_seen_reg <= 1'b0;
         else if (state_reg == msq_pkg::st_meas && fault_s2_reg)
            fault_seen_reg <= 1'b1;
         if (!cfg.err_sync)
            fault_out <= fault_s2_reg; // see RULE4
         else if (done)
            fault_out <= fault_seen_reg; // see RULE13
         if (done)
            comp_out <= comp_in; // see RULE19
      end
   end

   // Helpers for the checks below
   logic [31:0] ph_ticks_reg;
   logic [31:0] eoc_cyc_reg;
   logic [31:0] eoc_load_reg;
   logic [31:0] hold_now;
   logic [31:0] calc_now;
   logic [63:0] eoc_want;

   assign hold_now = hold_len(cfg.rate);
   assign calc_now = calc_len(cfg);
   assign eoc_want = 64'(eoc_load_reg) * 64'(TICK_CYCLES);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ph_ticks_reg <= 32'h0;
         eoc_cyc_reg  <= 32'h0;
         eoc_load_reg <= 32'h0;
      end
      else
      begin
         if (phase_end || state_reg == msq_pkg::st_idle)
            ph_ticks_reg <= 32'h0;
         else if (tick)
            ph_ticks_reg <= ph_ticks_reg + 32'h1;
         eoc_cyc_reg <= (eoc && !done) ? eoc_cyc_reg + 32'h1 : 32'h0;
         if (done)
            eoc_load_reg <= cfg.eoc_pulse ?
                            32'(32'(cfg.pulse_ms) * (`MSQ_MS_US / `MSQ_TICK_US)) : hold_now;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_eoc_timed_width: assert property ($fell(eoc) && $past(eoc_timed_reg) |->  // see RULE8
      eoc_want <= 64'(eoc_cyc_reg) + 64'(TICK_CYCLES) &&
      64'(eoc_cyc_reg) <= eoc_want + 64'h2)
      else $error("timed end-of-conversion has the wrong width");
   a_eoc_latched_hold: assert property (eoc && !eoc_timed_reg && !start_ev |=> eoc)  // see RULE7
      else $error("latched end-of-conversion dropped without a start");
   a_eoc_int_hold: assert property (done && cfg.start_strobe_n_internal && !cfg.eoc_pulse |=>  // see RULE9
      eoc_cnt_reg == $past(hold_now))
      else $error("internal hold time does not match the rate");
   a_fault_follows: assert property (!cfg.err_sync |=> fault_out == $past(fault_s2_reg))  // see RULE4
      else $error("asynchronous fault output lags");
   a_fault_sync_stable: assert property (cfg.err_sync && !done |=> $stable(fault_out))  // see RULE13
      else $error("synchronous fault changed outside completion");
   a_ext_one_start: assert property (state_reg == msq_pkg::st_idle && !cfg.start_strobe_n_internal  // see RULE15
      |=> (state_reg == msq_pkg::st_delay) == $past(fall))
      else $error("external start does not follow the falling edge");
   a_int_ignores_pin: assert property (state_reg == msq_pkg::st_idle && cfg.start_strobe_n_internal  // see RULE16
      |=> state_reg == msq_pkg::st_delay)
      else $error("internal trigger did not start regardless of the pin");
   a_removal_phase: assert property (removal_out == (state_reg != msq_pkg::st_meas))  // see RULE17
      else $error("removal indicator disagrees with the phase");
   a_meas_length: assert property (state_reg == msq_pkg::st_meas && cnt_reg == 32'h0  // see RULE5
      |-> ph_ticks_reg == meas_len_reg)
      else $error("measurement interval length is wrong");
   a_calc_length: assert property (state_reg == msq_pkg::st_calc && cnt_reg == 32'h0  // see RULE6
      |-> ph_ticks_reg == calc_now)
      else $error("calculation interval length is wrong");
   a_cycle_order: assert property (done |=> state_reg == msq_pkg::st_idle && eoc &&  // see RULE19
      comp_out == $past(comp_in))
      else $error("results not published together at completion");
   a_powerup_state: assert property (@(posedge ref_clk) disable iff (1'b0)  // see RULE18
      $fell(rst) |-> eoc && removal_out)
      else $error("outputs not asserted after power-up");

   c_ext_cycle: cover property (done && !cfg.start_strobe_n_internal && !cfg.eoc_pulse);
   c_pulse_end: cover property ($fell(eoc) && cfg.eoc_pulse);
   c_int_cycle: cover property (done && cfg.start_strobe_n_internal);
   c_sync_fault: cover property (done && cfg.err_sync && fault_seen_reg);

endmodule : msq_sequencer

`default_nettype wire

// File: dv/msq_ctrl_model.sv
/*
 Model of the external automation controller: on request it waits out the
 settling time of the test object, then pulls the start strobe low.
 Assumes one ref_clk and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module msq_ctrl_model
#(
   parameter int SETTLE_CYC = 1300,
   parameter int LOW_CYC    = 220
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Request from the bench
   input  wire logic start_strobe_n_req,
   // Control pin
   output logic      start_strobe_n
);

   int cnt_reg;

   // Requests while a strobe is in flight are dropped, like a real controller
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg        <= 0;
         start_strobe_n <= 1'b1;
      end
      else if (start_strobe_n_req && cnt_reg == 0)
         cnt_reg <= SETTLE_CYC + LOW_CYC;
      else if (cnt_reg != 0)
      begin
         cnt_reg        <= cnt_reg - 1;
         start_strobe_n <= !(cnt_reg <= LOW_CYC && cnt_reg > 1);
      end
   end

endmodule : msq_ctrl_model

`default_nettype wire

// File: dv/msq_sequencer_tb.sv
/*
 Self-checking bench of the measurement sequencer: external and internal
 cycles, phase lengths, end-of-conversion styles and fault reporting.
 Assumes TICK_CYCLES is shortened to 4, so 1 ms is 400 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module msq_sequencer_tb;

   localparam int T     = 4;
   localparam int LIMIT = 20000;

   logic              ref_clk = 1'b0;
   logic              rst;
   logic              start_strobe_n;
   logic              fault_in;
   logic              start_strobe_n_req;
   msq_pkg::msq_cfg_t cfg;
   logic [6:0]        comp_in;
   logic              eoc;
   logic              removal_out;
   logic              fault_out;
   logic [6:0]        comp_out;
   int                err_count;
   int                compares;
   int                n;

   always #5 ref_clk = ~ref_clk;

   msq_sequencer #(.TICK_CYCLES(T), .COMP_W(7)) u_msq_sequencer (
      .ref_clk(ref_clk), .rst(rst), .start_strobe_n(start_strobe_n),
      .fault_in(fault_in), .cfg(cfg), .comp_in(comp_in), .eoc(eoc),
      .removal_out(removal_out), .fault_out(fault_out), .comp_out(comp_out));

   msq_ctrl_model u_msq_ctrl_model (
      .ref_clk(ref_clk), .rst(rst), .start_strobe_n_req(start_strobe_n_req),
      .start_strobe_n(start_strobe_n));

   task automatic finish_test();
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
         err_count++;
      end
   endtask : check

   // Phase lengths are only known to within one tick plus the sync stages
   task automatic near(input string what, input int seen, input int exp);
      check(what, (seen >= exp - 6 && seen <= exp + 6) ? exp : seen, exp);
   endtask : near

   // 0 eoc, 1 removal, 2 fault, 3 start pin; counts falling edges until seen
   task automatic wait_for(input int which, input logic val, output int cnt);
      logic s;
      cnt = 0;
      do
      begin
         @(negedge ref_clk);
         cnt++;
         s = (which == 0) ? eoc : (which == 1) ? removal_out :
             (which == 2) ? fault_out : start_strobe_n;
      end while (s !== val && cnt < LIMIT);
      if (cnt >= LIMIT)
      begin
         check("wait bound", cnt, 0);
         finish_test();
      end
   endtask : wait_for

   task automatic run_ext(input int dly, input int meas, input int calc, input logic flt);
      int c;
      @(posedge ref_clk);
      start_strobe_n_req <= 1'b1;
      @(posedge ref_clk);
      start_strobe_n_req <= 1'b0;
      wait_for(3, 1'b0, c);
      wait_for(1, 1'b0, c);
      near("delay", c, dly * T + 4);
      check("eoc at start", eoc, 1'b0);
      @(posedge ref_clk);
      fault_in <= flt;
      wait_for(1, 1'b1, c);
      near("meas", c + 1, meas * T);
      check("fault early", fault_out, 1'b0);
      wait_for(0, 1'b1, c);
      near("calc", c, calc * T);
      check("comp", comp_out, comp_in);
      check("fault sync", fault_out, flt);
      @(posedge ref_clk);
      fault_in <= 1'b0;
   endtask : run_ext

   initial
   begin
      rst       = 1'b1;
      cfg       = '0;
      comp_in   = 7'h00;
      fault_in  = 1'b0;
      start_strobe_n_req  = 1'b0;
      err_count = 0;
      compares  = 0;
      repeat (12) @(posedge ref_clk);
      check("eoc reset", eoc, 1'b1);
      check("removal reset", removal_out, 1'b1);
      check("fault reset", fault_out, 1'b0);
      rst     <= 1'b0;
      comp_in <= 7'h5A;
      run_ext(0, 340, 30, 1'b0);
      repeat (3000) @(posedge ref_clk);
      check("eoc latched", eoc, 1'b1);
      cfg.combined    <= 1'b1;
      cfg.stats_on    <= 1'b1;
      cfg.ref_tol     <= 1'b1;
      cfg.delay_ticks <= 16'h0032;
      comp_in         <= 7'h25;
      run_ext(50, 680, 75, 1'b0);
      cfg.combined    <= 1'b0;
      cfg.stats_on    <= 1'b0;
      cfg.ref_tol     <= 1'b0;
      cfg.delay_ticks <= 16'h0000;
      cfg.rate        <= msq_pkg::rate_fast;
      cfg.avg_on      <= 1'b1;
      cfg.avg_n       <= 8'h03;
      run_ext(0, 3140, 30, 1'b0);
      cfg.avg_on      <= 1'b0;
      cfg.rate        <= msq_pkg::rate_extra_quick;
      cfg.eoc_pulse   <= 1'b1;
      cfg.pulse_ms    <= 16'h0002;
      run_ext(0, 340, 30, 1'b0);
      wait_for(0, 1'b0, n);
      near("pulse width", n, 800);
      @(posedge ref_clk);
      cfg.eoc_pulse     <= 1'b0;
      cfg.start_strobe_n_internal <= 1'b1;
      cfg.avg_on        <= 1'b1;
      cfg.avg_n         <= 8'h04;
      start_strobe_n_req          <= 1'b1;
      wait_for(1, 1'b0, n);
      wait_for(1, 1'b1, n);
      near("internal meas", n, 1360);
      wait_for(0, 1'b1, n);
      wait_for(0, 1'b0, n);
      near("internal hold", n, 400);
      @(posedge ref_clk);
      start_strobe_n_req          <= 1'b0;
      cfg.start_strobe_n_internal <= 1'b0;
      cfg.avg_on        <= 1'b0;
      wait_for(0, 1'b1, n);
      // A strobe still in flight from the controller may start one stray cycle
      repeat (3000) @(posedge ref_clk);
      cfg.err_sync <= 1'b1;
      run_ext(0, 340, 30, 1'b1);
      @(posedge ref_clk);
      cfg.err_sync <= 1'b0;
      wait_for(2, 1'b0, n);
      @(posedge ref_clk);
      fault_in <= 1'b1;
      wait_for(2, 1'b1, n);
      check("fault rise in time", n <= 600, 1'b1);
      @(posedge ref_clk);
      fault_in <= 1'b0;
      wait_for(2, 1'b0, n);
      check("fault fall in time", n <= 600, 1'b1);
      finish_test();
   end

endmodule : msq_sequencer_tb

`default_nettype wire
